//--- trim_and_swap_delay_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - an 8-bit read/write core gain trim in bits 7:0 acts on all converter cores together.
// - a 4-bit read/write band-gap trim sits in bits 3:0 with bits 7:4 reserved.
// - after reset every trim holds its factory fuse value, readable and overwritable by software.
// - four independent 8-bit read/write termination trims serve the four input channels.
// - the swap overlap setting is a 5-bit field in bits 4:0, any value 0 to 31, resetting to 0x08.
// - during a core swap both cores sample together for four plus twice the setting converter clocks.
module trim_and_swap_delay_regs
   import trim_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [11:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // factory fuse image
   input  wire fuse_image_t       fuse_image,
   // core swap request and calibration state
   input  wire logic              swap_start,
   input  wire logic              cal_enable,
   // trim controls
   output logic      [TRIM_W-1:0] core_gain_adjust,
   output logic      [BG_W-1:0]   bandgap_adjust,
   output logic      [TRIM_W-1:0] termination_adjust_ch1,
   output logic      [TRIM_W-1:0] termination_adjust_ch2,
   output logic      [TRIM_W-1:0] termination_adjust_ch3,
   output logic      [TRIM_W-1:0] termination_adjust_ch4,
   output logic      [OVL_W-1:0]  swap_overlap_length,
   output logic                   swap_overlap_active
);
   // ****************************************
   // bus front end
   // ****************************************
   ahb_req_t               req_r, req_nxt;
   logic                   fuse_load_r, fuse_load_nxt;
   logic                   viol_r, viol_nxt;
   logic [TRIM_W-1:0]      gain_r, gain_nxt;
   logic [BG_W-1:0]        bg_r, bg_nxt;
   logic [TRIM_W-1:0]      t1_r, t1_nxt, t2_r, t2_nxt;
   logic [TRIM_W-1:0]      t3_r, t3_nxt, t4_r, t4_nxt;
   logic [OVL_W-1:0]       ovl_r, ovl_nxt;
   logic [31:0]            rdata_r, rdata_nxt;
   logic                   active_r;
   logic                   ovl_busy;
   logic                   take;

   // always zero wait states; a single-cycle data phase
   assign take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

   always_comb begin
      req_nxt.wr  = take && hwrite;
      req_nxt.rd  = take && !hwrite;
      req_nxt.idx = haddr[ADDR_LSB +: IDX_W];
   end

   // ****************************************
   // register bank
   // ****************************************
   always_comb begin
      fuse_load_nxt = 1'b0;
      gain_nxt      = gain_r;
      bg_nxt        = bg_r;
      t1_nxt        = t1_r;
      t2_nxt        = t2_r;
      t3_nxt        = t3_r;
      t4_nxt        = t4_r;
      ovl_nxt       = ovl_r;
      viol_nxt      = viol_r;
      if (fuse_load_r) begin
         // fuses are sampled one cycle after reset release, never under reset
         gain_nxt = fuse_image.core_gain;
         bg_nxt   = fuse_image.bandgap;
         t1_nxt   = fuse_image.term_ch1;
         t2_nxt   = fuse_image.term_ch2;
         t3_nxt   = fuse_image.term_ch3;
         t4_nxt   = fuse_image.term_ch4;
      end else if (req_r.wr) begin
         case (req_r.idx)
            IDX_CORE_GAIN: gain_nxt = hwdata[TRIM_W-1:0];
            IDX_BANDGAP:   bg_nxt   = hwdata[BG_W-1:0];
            IDX_TERM_CH1:  t1_nxt   = hwdata[TRIM_W-1:0];
            IDX_TERM_CH2:  t2_nxt   = hwdata[TRIM_W-1:0];
            IDX_TERM_CH3:  t3_nxt   = hwdata[TRIM_W-1:0];
            IDX_TERM_CH4:  t4_nxt   = hwdata[TRIM_W-1:0];
            IDX_SWAP_OVL: begin
               ovl_nxt = hwdata[OVL_W-1:0];
               // write still lands, but the misuse is flagged for software
               if (cal_enable) begin
                  viol_nxt = 1'b1;
               end
            end
            IDX_STATUS:    viol_nxt = viol_r & ~hwdata[0];
            default:       viol_nxt = viol_r;
         endcase
      end
   end

   // read data is registered from the address phase; reserved bits read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (req_nxt.rd) begin
         case (req_nxt.idx)
            IDX_CORE_GAIN: rdata_nxt[TRIM_W-1:0] = gain_nxt;
            IDX_BANDGAP:   rdata_nxt[BG_W-1:0]   = bg_nxt;
            IDX_TERM_CH1:  rdata_nxt[TRIM_W-1:0] = t1_nxt;
            IDX_TERM_CH2:  rdata_nxt[TRIM_W-1:0] = t2_nxt;
            IDX_TERM_CH3:  rdata_nxt[TRIM_W-1:0] = t3_nxt;
            IDX_TERM_CH4:  rdata_nxt[TRIM_W-1:0] = t4_nxt;
            IDX_SWAP_OVL:  rdata_nxt[OVL_W-1:0]  = ovl_nxt;
            IDX_CTRL:      rdata_nxt[0]          = cal_enable;
            IDX_STATUS:    rdata_nxt             = {30'h0, ovl_busy, viol_nxt};
            default:       rdata_nxt             = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         req_r       <= '0;
         fuse_load_r <= 1'b1;
         gain_r      <= 8'h00;
         bg_r        <= 4'h0;
         t1_r        <= 8'h00;
         t2_r        <= 8'h00;
         t3_r        <= 8'h00;
         t4_r        <= 8'h00;
         ovl_r       <= OVL_RESET;
         viol_r      <= 1'b0;
         rdata_r     <= 32'h0000_0000;
         active_r    <= 1'b0;
      end else begin
         req_r       <= req_nxt;
         fuse_load_r <= fuse_load_nxt;
         gain_r      <= gain_nxt;
         bg_r        <= bg_nxt;
         t1_r        <= t1_nxt;
         t2_r        <= t2_nxt;
         t3_r        <= t3_nxt;
         t4_r        <= t4_nxt;
         ovl_r       <= ovl_nxt;
         viol_r      <= viol_nxt;
         rdata_r     <= rdata_nxt;
         active_r    <= ovl_busy;
      end
   end

   // ****************************************
   // swap overlap window
   // ****************************************
   swap_overlap_timer u_timer (
      .core_clk        (core_clk),
      .rst             (rst),
      .swap_start      (swap_start),
      .overlap_setting (ovl_r),
      .overlap_active  (ovl_busy)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign hrdata                 = rdata_r;
   assign hreadyout              = 1'b1;
   assign hresp                  = 1'b0;
   assign core_gain_adjust       = gain_r;
   assign bandgap_adjust         = bg_r;
   assign termination_adjust_ch1 = t1_r;
   assign termination_adjust_ch2 = t2_r;
   assign termination_adjust_ch3 = t3_r;
   assign termination_adjust_ch4 = t4_r;
   assign swap_overlap_length    = ovl_r;
   assign swap_overlap_active    = active_r;

   // ****************************************
   // checks
   // ****************************************
   a_fuse_preset: assert property (@(posedge core_clk) disable iff (rst)
      fuse_load_r |=> (gain_r == $past(fuse_image.core_gain) && t4_r == $past(fuse_image.term_ch4)))
      else $error("trims not preset from fuses");
   a_gain_write: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_CORE_GAIN) |=> gain_r == $past(hwdata[7:0]))
      else $error("gain write lost");
   a_bandgap_write: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_BANDGAP) |=> bg_r == $past(hwdata[3:0]))
      else $error("bandgap write lost");
   a_term_write: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_TERM_CH3) |=> (t3_r == $past(hwdata[7:0])
      && $stable(t2_r) && $stable(t4_r)))
      else $error("termination write wrong");
   a_overlap_reset: assert property (@(posedge core_clk)
      rst |=> ovl_r == OVL_RESET)
      else $error("overlap setting reset value wrong");
   a_overlap_write: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_SWAP_OVL) |=> ovl_r == $past(hwdata[4:0]))
      else $error("overlap write lost");
   a_cal_misuse: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_SWAP_OVL && cal_enable) |=> viol_r)
      else $error("write during calibration not flagged");
   a_read_back: assert property (@(posedge core_clk) disable iff (rst)
      (req_nxt.rd && req_nxt.idx == IDX_TERM_CH1 && !fuse_load_r && !req_r.wr) |=> hrdata[7:0] == t1_r)
      else $error("termination read back wrong");
   a_hold_value: assert property (@(posedge core_clk) disable iff (rst)
      (!req_r.wr && !fuse_load_r) |=> $stable(gain_r) && $stable(ovl_r))
      else $error("register changed without write");
   c_gain_write: cover property (@(posedge core_clk) disable iff (rst)
      req_r.wr && req_r.idx == IDX_CORE_GAIN);
   c_overlap_read: cover property (@(posedge core_clk) disable iff (rst)
      req_r.rd && req_r.idx == IDX_SWAP_OVL);
   c_cal_misuse: cover property (@(posedge core_clk) disable iff (rst) $rose(viol_r));

   // ****************************************
   // read path and bank checks
   // ****************************************
   a_term1_write: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_TERM_CH1) |=> t1_r == $past(hwdata[7:0]))
      else $error("termination ch1 write lost");

   a_term2_write: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_TERM_CH2) |=> t2_r == $past(hwdata[7:0]))
      else $error("termination ch2 write lost");

   a_term4_write: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_TERM_CH4) |=> t4_r == $past(hwdata[7:0]))
      else $error("termination ch4 write lost");

   a_fuse_rest: assert property (@(posedge core_clk) disable iff (rst)
      fuse_load_r |=> (bg_r == $past(fuse_image.bandgap) && t1_r == $past(fuse_image.term_ch1)
      && t2_r == $past(fuse_image.term_ch2) && t3_r == $past(fuse_image.term_ch3)))
      else $error("remaining trims not preset from fuses");

   a_gain_read: assert property (@(posedge core_clk) disable iff (rst)
      (req_nxt.rd && req_nxt.idx == IDX_CORE_GAIN) |=> hrdata == {24'h0, gain_r})
      else $error("gain read back wrong");

   a_bandgap_read: assert property (@(posedge core_clk) disable iff (rst)
      (req_nxt.rd && req_nxt.idx == IDX_BANDGAP) |=> hrdata == {28'h0, bg_r})
      else $error("bandgap read back wrong or reserved bits set");

   a_overlap_read: assert property (@(posedge core_clk) disable iff (rst)
      (req_nxt.rd && req_nxt.idx == IDX_SWAP_OVL) |=> hrdata == {27'h0, ovl_r})
      else $error("overlap read back wrong");

   // read data stands for one data phase only, so a stale word never leaks into a write cycle
   a_read_idle: assert property (@(posedge core_clk) disable iff (rst)
      !req_nxt.rd |=> hrdata == 32'h0000_0000)
      else $error("read data not zero outside a read");

   a_ctrl_read: assert property (@(posedge core_clk) disable iff (rst)
      (req_nxt.rd && req_nxt.idx == IDX_CTRL) |=> hrdata == {31'h0, $past(cal_enable)})
      else $error("calibration state read wrong");

   a_status_clear: assert property (@(posedge core_clk) disable iff (rst)
      (req_r.wr && !fuse_load_r && req_r.idx == IDX_STATUS && hwdata[0]) |=> !viol_r)
      else $error("misuse flag not cleared");

   a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
      (viol_r && !(req_r.wr && !fuse_load_r && req_r.idx == IDX_STATUS)) |=> viol_r)
      else $error("misuse flag dropped without clear");

   a_flag_quiet: assert property (@(posedge core_clk) disable iff (rst)
      (!viol_r && !(req_r.wr && !fuse_load_r && req_r.idx == IDX_SWAP_OVL && cal_enable)) |=> !viol_r)
      else $error("misuse flag set without misuse");

   // ****************************************
   // swap window length
   // ****************************************
   // windows run up to 66 cycles, too long to unroll, so a counter measures them
   logic [CNT_W-1:0]       win_cnt_r, win_cnt_nxt;

   always_comb begin
      win_cnt_nxt = 7'h00;
      if (ovl_busy) begin
         win_cnt_nxt = win_cnt_r + 7'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         win_cnt_r <= 7'h00;
      end else begin
         win_cnt_r <= win_cnt_nxt;
      end
   end

   // limitation: assumes the setting is not rewritten while a window runs
   a_window_length: assert property (@(posedge core_clk) disable iff (rst)
      $fell(ovl_busy) |-> win_cnt_r == OVL_BASE + {1'b0, ovl_r, 1'b0})
      else $error("overlap window length wrong");

   c_status_clear: cover property (@(posedge core_clk) disable iff (rst) $fell(viol_r));
endmodule : trim_and_swap_delay_regs

//--- trim_pkg.sv
package trim_pkg;
   // ****************************************
   // register indices (printed offsets are not all word aligned)
   // ****************************************
   localparam logic [9:0] IDX_CORE_GAIN   = 10'h07A;
   localparam logic [9:0] IDX_BANDGAP     = 10'h07C;
   localparam logic [9:0] IDX_TERM_CH1    = 10'h07E;
   localparam logic [9:0] IDX_TERM_CH2    = 10'h07F;
   localparam logic [9:0] IDX_TERM_CH3    = 10'h080;
   localparam logic [9:0] IDX_TERM_CH4    = 10'h081;
   localparam logic [9:0] IDX_SWAP_OVL    = 10'h09A;
   localparam logic [9:0] IDX_CTRL        = 10'h0A0;
   localparam logic [9:0] IDX_STATUS      = 10'h0A1;
   localparam int         IDX_W           = 10;
   localparam int         ADDR_LSB        = 2;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int         TRIM_W          = 8;
   localparam int         BG_W            = 4;
   localparam int         OVL_W           = 5;
   localparam logic [4:0] OVL_RESET       = 5'h08;
   localparam int         CNT_W           = 7;
   localparam logic [6:0] OVL_BASE        = 7'h04;
   localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
   localparam logic [2:0] HSIZE_WORD      = 3'h2;

   // factory fuse image presented to the bank
   typedef struct packed {
      logic [7:0] core_gain;
      logic [3:0] bandgap;
      logic [7:0] term_ch1;
      logic [7:0] term_ch2;
      logic [7:0] term_ch3;
      logic [7:0] term_ch4;
   } fuse_image_t;

   // ahb-lite address phase captured for the data phase
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [9:0] idx;
   } ahb_req_t;

   typedef enum logic [1:0] {
      SW_IDLE    = 2'b00,
      SW_OVERLAP = 2'b01
   } swap_state_t;
endpackage : trim_pkg

//--- swap_overlap_timer.sv
`timescale 1ns/1ps
// counts the dual-sampling window of a background core swap
module swap_overlap_timer
   import trim_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // control
   input  wire logic             swap_start,
   input  wire logic [OVL_W-1:0] overlap_setting,
   // status
   output logic                  overlap_active
);
   swap_state_t            state_r, state_nxt;
   logic [CNT_W-1:0]       cnt_r, cnt_nxt;
   logic [CNT_W-1:0]       len;

   // window is base plus twice the setting, in converter clocks
   assign len = OVL_BASE + {1'b0, overlap_setting, 1'b0};

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         SW_IDLE: begin
            if (swap_start) begin
               state_nxt = SW_OVERLAP;
               cnt_nxt   = len - 7'h01;
            end
         end
         SW_OVERLAP: begin
            if (cnt_r == 7'h00) begin
               state_nxt = SW_IDLE;
            end else begin
               cnt_nxt = cnt_r - 7'h01;
            end
         end
         default: state_nxt = SW_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= SW_IDLE;
         cnt_r   <= 7'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign overlap_active = (state_r == SW_OVERLAP);

   // ****************************************
   // checks
   // ****************************************
   a_overlap_min_len: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == SW_IDLE && swap_start && overlap_setting == 5'h00)
      |=> overlap_active [*4] ##1 !overlap_active)
      else $error("overlap window not four cycles at setting zero");
   c_overlap_run: cover property (@(posedge core_clk) disable iff (rst)
      $fell(overlap_active));
endmodule : swap_overlap_timer

//--- tb.sv
`timescale 1ns/1ps
module tb;
   import trim_pkg::*;
   // ****************************************
   // clock, reset and port signals
   // ****************************************
   logic        core_clk = 1'b0;
   logic        rst;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   fuse_image_t fuse_image;
   logic        swap_start;
   logic        cal_enable;
   logic [7:0]  core_gain_adjust;
   logic [3:0]  bandgap_adjust;
   logic [7:0]  term1;
   logic [7:0]  term2;
   logic [7:0]  term3;
   logic [7:0]  term4;
   logic [4:0]  swap_overlap_length;
   logic        swap_overlap_active;
   int          err_total = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   // fuse values chosen so every field differs from its neighbours
   localparam fuse_image_t FUSE = {8'hA5, 4'h9, 8'h11, 8'h22, 8'h33, 8'h44};
   logic [9:0]  idx_tab [7] = '{IDX_CORE_GAIN, IDX_BANDGAP, IDX_TERM_CH1, IDX_TERM_CH2,
                                IDX_TERM_CH3, IDX_TERM_CH4, IDX_SWAP_OVL};

   always #12.5 core_clk = ~core_clk;

   // hreadyout is the only slave, so it is the bus ready
   trim_and_swap_delay_regs i_trim_and_swap_delay_regs (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .fuse_image(fuse_image), .swap_start(swap_start),
      .cal_enable(cal_enable), .core_gain_adjust(core_gain_adjust), .bandgap_adjust(bandgap_adjust),
      .termination_adjust_ch1(term1), .termination_adjust_ch2(term2),
      .termination_adjust_ch3(term3), .termination_adjust_ch4(term4),
      .swap_overlap_length(swap_overlap_length), .swap_overlap_active(swap_overlap_active));

   // ****************************************
   // shared tasks
   // ****************************************
   task test_done;
      if (err_total == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : check

   // single word transfer; no fixed latency assumed, ready is polled
   task xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      hsel   <= 1'b1;
      haddr  <= {idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task rd_chk(input string what, input logic [9:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      xfer(1'b0, idx, 32'h0, d);
      check(what, {24'h0, exp}, d);
      check("hresp", 32'h0, {31'h0, hresp});
   endtask : rd_chk

   task out_chk(input logic [7:0] ev [7]);
      check("core gain out", ev[0], core_gain_adjust);
      check("bandgap out", ev[1], {4'h0, bandgap_adjust});
      check("term ch1 out", ev[2], term1);
      check("term ch2 out", ev[3], term2);
      check("term ch3 out", ev[4], term3);
      check("term ch4 out", ev[5], term4);
      check("overlap out", ev[6], {3'h0, swap_overlap_length});
   endtask : out_chk

   // ****************************************
   // scenarios
   // ****************************************
   task t_fuse;
      logic [7:0] ev [7];
      ev = '{FUSE.core_gain, {4'h0, FUSE.bandgap}, FUSE.term_ch1, FUSE.term_ch2,
             FUSE.term_ch3, FUSE.term_ch4, {3'h0, OVL_RESET}};
      out_chk(ev);
      for (int i = 0; i < 7; i++)
         rd_chk("reset readback", idx_tab[i], ev[i]);
   endtask : t_fuse

   task t_rw;
      logic [31:0] d;
      logic [7:0]  ev [7];
      ev = '{8'h5A, 8'h06, 8'hFF, 8'h00, 8'h81, 8'h7E, 8'h1F};
      for (int i = 0; i < 7; i++)
         xfer(1'b1, idx_tab[i], {24'h0, ev[i]}, d);
      for (int i = 0; i < 7; i++)
         rd_chk("readback", idx_tab[i], ev[i]);
      out_chk(ev);
      xfer(1'b1, 10'h07B, 32'h0000_00C3, d);
      rd_chk("unmapped read", 10'h07B, 8'h00);
      rd_chk("gain after unmapped write", IDX_CORE_GAIN, 8'h5A);
   endtask : t_rw

   // calibration stays disabled while the setting is written
   task t_swap(input logic [4:0] s);
      logic [31:0] d;
      int          n;
      cal_enable <= 1'b0;
      xfer(1'b1, IDX_SWAP_OVL, {27'h0, s}, d);
      @(posedge core_clk);
      check("overlap setting", {27'h0, s}, {27'h0, swap_overlap_length});
      swap_start <= 1'b1;
      @(posedge core_clk);
      swap_start <= 1'b0;
      n = 0;
      for (int k = 0; k < 200; k++) begin
         @(posedge core_clk);
         if (swap_overlap_active === 1'b1)
            n++;
         else if (n > 0)
            break;
      end
      check("overlap cycles", 32'd4 + 32'd2 * s, n);
   endtask : t_swap

   // reset in mid run: trims clear under reset, then reload from the fuses
   task t_reset;
      logic [7:0] ev [7];
      ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, {3'h0, OVL_RESET}};
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (5) @(posedge core_clk);
      out_chk(ev);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_fuse();
   endtask : t_reset

   // misuse on purpose: a setting write under calibration lands but stays flagged until cleared
   task t_cal;
      logic [31:0] d;
      cal_enable <= 1'b1;
      rd_chk("ctrl cal bit", IDX_CTRL, 8'h01);
      xfer(1'b1, IDX_SWAP_OVL, {27'h0, OVL_RESET}, d);
      rd_chk("misuse flag", IDX_STATUS, 8'h01);
      rd_chk("setting under cal", IDX_SWAP_OVL, {3'h0, OVL_RESET});
      xfer(1'b1, IDX_STATUS, 32'h0000_0001, d);
      rd_chk("misuse flag cleared", IDX_STATUS, 8'h00);
      cal_enable <= 1'b0;
      rd_chk("ctrl cal bit off", IDX_CTRL, 8'h00);
   endtask : t_cal

   // ****************************************
   // timeout and main sequence
   // ****************************************
   // whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         test_done();
      end
   end

   initial begin
      rst        = 1'b1;
      hsel       = 1'b0;
      haddr      = 12'h000;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hsize      = 3'h0;
      hwdata     = 32'h0;
      fuse_image = FUSE;
      swap_start = 1'b0;
      cal_enable = 1'b0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_fuse();
      t_rw();
      t_reset();
      t_swap(5'h00);
      t_swap(5'h07);
      t_swap(OVL_RESET);
      t_swap(5'h1F);
      t_cal();
      test_done();
   end
endmodule : tb
